// [rtl/umaf_pkg.sv]
// package: register offsets, field positions and reset values for the address filter
package umaf_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_CSA = 3'h1;
  localparam logic [2:0] OFF_CSB = 3'h2;
  localparam logic [2:0] OFF_SHARED = 3'h3;
  // ctrl_status_a fields
  localparam int CSA_FILTER = 0;
  localparam int CSA_TXC = 6;
  localparam int CSA_RXC = 7;
  // ctrl_status_b fields
  localparam int CSB_SIZE2 = 2;
  localparam int CSB_RX9 = 1;
  localparam int CSB_TX9 = 0;
  // frame configuration fields
  localparam int CFG_SEL = 7;
  localparam int CFG_TWO_STOP = 3;
  localparam int CFG_SIZE0 = 1;
  // reset values and character size codes
  localparam logic [7:0] CFG_RESET = 8'h86;
  localparam logic [7:0] BAUD_HI_RESET = 8'h00;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [2:0] SIZE_EIGHT = 3'h3;
endpackage : umaf_pkg

// [rtl/umaf_frame_class.sv]
// frame classifier: picks the frame-type bit and decides whether a frame is kept
`timescale 1ns/1ps
`default_nettype none
module umaf_frame_class (
  // configuration
  input wire logic [2:0] char_size_sel,
  input wire logic addr_filter_en,
  // received frame
  input wire logic rx_ninth_bit,
  input wire logic rx_first_stop,
  // decision
  output logic is_address,
  output logic keep_frame
);
  always_comb begin
    // nine-bit frames carry the type in the ninth bit, others in the first stop bit
    if (char_size_sel == umaf_pkg::SIZE_NINE) begin
      is_address = rx_ninth_bit;
    end else begin
      is_address = rx_first_stop;
    end
    keep_frame = !addr_filter_en || is_address;
  end
endmodule : umaf_frame_class
`default_nettype wire

// [rtl/umaf_top.sv]
// receive address filter and shared baud-high / frame-config register access
`timescale 1ns/1ps
`default_nettype none
module umaf_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // receiver frame in
  input wire logic rx_frame_valid,
  input wire logic [7:0] rx_frame_data,
  input wire logic rx_frame_bit8,
  input wire logic rx_frame_stop,
  // transmitter events and controls
  input wire logic tx_done_pulse,
  output logic tx_ninth_bit,
  output logic [2:0] char_size_sel,
  output logic two_stop_sel,
  output logic [7:0] baud_div_high,
  // receive status
  output logic rx_complete_flag
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic addr_filter_en_reg, addr_filter_en_next;
  logic tx_complete_reg, tx_complete_next;
  logic rx_full_reg, rx_full_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_ninth_reg, rx_ninth_next;
  logic size2_reg, size2_next;
  logic tx_ninth_reg, tx_ninth_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] baud_hi_reg, baud_hi_next;
  logic shared_rd_reg, shared_rd_next;
  logic [7:0] rdata_reg, rdata_next;
  logic is_address;
  logic keep_frame;
  logic [2:0] size_sel;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  // one size setting feeds both directions
  assign size_sel = {size2_reg, cfg_reg[umaf_pkg::CFG_SIZE0+1], cfg_reg[umaf_pkg::CFG_SIZE0]};

  umaf_frame_class u_class (
    .char_size_sel(size_sel),
    .addr_filter_en(addr_filter_en_reg),
    .rx_ninth_bit(rx_frame_bit8),
    .rx_first_stop(rx_frame_stop),
    .is_address(is_address),
    .keep_frame(keep_frame)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    addr_filter_en_next = addr_filter_en_reg;
    tx_complete_next = tx_complete_reg;
    rx_full_next = rx_full_reg;
    rx_data_next = rx_data_reg;
    rx_ninth_next = rx_ninth_reg;
    size2_next = size2_reg;
    tx_ninth_next = tx_ninth_reg;
    cfg_next = cfg_reg;
    baud_hi_next = baud_hi_reg;
    rdata_next = 8'h00;
    shared_rd_next = reg_rd && hit(reg_addr, umaf_pkg::OFF_SHARED);
    if (reg_rd) begin
      unique case (reg_addr)
        umaf_pkg::OFF_DATA: begin
          rdata_next = rx_data_reg;
          rx_full_next = 1'b0;
        end
        umaf_pkg::OFF_CSA: begin
          rdata_next = 8'h00;
          rdata_next[umaf_pkg::CSA_RXC] = rx_full_reg;
          rdata_next[umaf_pkg::CSA_TXC] = tx_complete_reg;
          rdata_next[umaf_pkg::CSA_FILTER] = addr_filter_en_reg;
        end
        umaf_pkg::OFF_CSB: begin
          rdata_next = 8'h00;
          rdata_next[umaf_pkg::CSB_SIZE2] = size2_reg;
          rdata_next[umaf_pkg::CSB_RX9] = rx_ninth_reg;
          rdata_next[umaf_pkg::CSB_TX9] = tx_ninth_reg;
        end
        umaf_pkg::OFF_SHARED: begin
          if (shared_rd_reg) begin
            rdata_next = cfg_reg | (8'h01 << umaf_pkg::CFG_SEL);
          end else begin
            rdata_next = baud_hi_reg;
          end
        end
        default: rdata_next = 8'h00;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        umaf_pkg::OFF_CSA: begin
          addr_filter_en_next = reg_wdata[umaf_pkg::CSA_FILTER];
          if (reg_wdata[umaf_pkg::CSA_TXC]) begin
            tx_complete_next = 1'b0;
          end
        end
        umaf_pkg::OFF_CSB: begin
          size2_next = reg_wdata[umaf_pkg::CSB_SIZE2];
          tx_ninth_next = reg_wdata[umaf_pkg::CSB_TX9];
        end
        umaf_pkg::OFF_SHARED: begin
          if (reg_wdata[umaf_pkg::CFG_SEL]) begin
            cfg_next = reg_wdata;
          end else begin
            baud_hi_next = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over software clear
    if (tx_done_pulse) begin
      tx_complete_next = 1'b1;
    end
    if (rx_frame_valid && keep_frame) begin
      rx_data_next = rx_frame_data;
      rx_ninth_next = rx_frame_bit8;
      rx_full_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_filter_en_reg <= 1'b0;
      tx_complete_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      rx_data_reg <= 8'h00;
      rx_ninth_reg <= 1'b0;
      size2_reg <= 1'b0;
      tx_ninth_reg <= 1'b0;
      cfg_reg <= umaf_pkg::CFG_RESET;
      baud_hi_reg <= umaf_pkg::BAUD_HI_RESET;
      shared_rd_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      addr_filter_en_reg <= addr_filter_en_next;
      tx_complete_reg <= tx_complete_next;
      rx_full_reg <= rx_full_next;
      rx_data_reg <= rx_data_next;
      rx_ninth_reg <= rx_ninth_next;
      size2_reg <= size2_next;
      tx_ninth_reg <= tx_ninth_next;
      cfg_reg <= cfg_next;
      baud_hi_reg <= baud_hi_next;
      shared_rd_reg <= shared_rd_next;
      rdata_reg <= rdata_next;
    end
  end

  // transmit controls never look at the filter enable
  assign tx_ninth_bit = tx_ninth_reg;
  assign char_size_sel = size_sel;
  assign two_stop_sel = cfg_reg[umaf_pkg::CFG_TWO_STOP];
  assign baud_div_high = baud_hi_reg;
  assign rx_complete_flag = rx_full_reg;
  assign reg_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_shared_rd;
    reg_rd && reg_addr == umaf_pkg::OFF_SHARED;
  endsequence

  sequence s_no_shared_rd;
    !(reg_rd && reg_addr == umaf_pkg::OFF_SHARED);
  endsequence

  AST_DROP_DATA: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_frame_valid && addr_filter_en_reg && !is_address && !(reg_rd && reg_addr == umaf_pkg::OFF_DATA)
    |=> rx_full_reg == $past(rx_full_reg) && rx_data_reg == $past(rx_data_reg))
    else $error("data frame stored while filtering");
  AST_STOP_TYPE: assert property (@(posedge sys_clk) disable iff (!resetn)
    size_sel != umaf_pkg::SIZE_NINE |-> is_address == rx_frame_stop)
    else $error("stop bit not used as frame type");
  AST_NINTH_TYPE: assert property (@(posedge sys_clk) disable iff (!resetn)
    size_sel == umaf_pkg::SIZE_NINE |-> is_address == rx_frame_bit8)
    else $error("ninth bit not used as frame type");
  AST_ADDR_STORED: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_frame_valid && is_address |=> rx_complete_flag && rx_data_reg == $past(rx_frame_data))
    else $error("address frame not stored");
  AST_WR_BAUD: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == umaf_pkg::OFF_SHARED && !reg_wdata[7]
    |=> baud_div_high == $past(reg_wdata) && $stable(cfg_reg))
    else $error("baud high write misrouted");
  AST_WR_CFG: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == umaf_pkg::OFF_SHARED && reg_wdata[7]
    |=> cfg_reg == $past(reg_wdata) && $stable(baud_div_high))
    else $error("config write misrouted");
  AST_RD_SINGLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_no_shared_rd ##1 s_shared_rd |=> reg_rdata == $past(baud_hi_reg))
    else $error("single read not baud high");
  AST_RD_DOUBLE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_shared_rd ##1 s_shared_rd |=> reg_rdata == ($past(cfg_reg) | 8'h80) && reg_rdata[7])
    else $error("double read not frame config");
  AST_TXC_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_addr == umaf_pkg::OFF_CSA && reg_wdata[6] && !tx_done_pulse |=> !tx_complete_reg)
    else $error("transmit complete not cleared");
endmodule : umaf_top
`default_nettype wire

// [test/umaf_node_model.sv]
// far-side serial node: hands finished frames to the receiver one at a time
`timescale 1ns/1ps
`default_nettype none
module umaf_node_model (
  // clock
  input wire logic sys_clk,
  // frame out
  output logic valid,
  output logic [7:0] data,
  output logic bit8,
  output logic stop
);
  initial begin
    valid = 1'b0;
    data = 8'h00;
    bit8 = 1'b0;
    stop = 1'b1;
  end
  // ninth bit and first stop bit are set by the caller as the frame type
  task automatic send(input logic [7:0] d, input logic b8, input logic st);
    @(posedge sys_clk);
    valid <= 1'b1;
    data <= d;
    bit8 <= b8;
    stop <= st;
    @(posedge sys_clk);
    valid <= 1'b0;
    // lines are stale once the strobe drops, so show the inverse
    data <= ~d;
    bit8 <= ~b8;
    stop <= ~st;
  endtask : send
endmodule : umaf_node_model
`default_nettype wire

// [test/umaf_top_tb_top.sv]
// testbench for the receive address filter and shared register access
`timescale 1ns/1ps
`default_nettype none
module umaf_top_tb_top;
  logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_done_pulse = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, rx_data, baud_div_high;
  logic rx_valid, rx_bit8, rx_stop, tx_ninth_bit, two_stop_sel, rx_complete_flag;
  logic [2:0] char_size_sel;
  logic [7:0] got [0:2];
  int fails = 0;
  int n_checks = 0;
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  umaf_node_model node (.sys_clk(sys_clk), .valid(rx_valid), .data(rx_data), .bit8(rx_bit8), .stop(rx_stop));
  umaf_top dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame_valid(rx_valid),
    .rx_frame_data(rx_data), .rx_frame_bit8(rx_bit8), .rx_frame_stop(rx_stop),
    .tx_done_pulse(tx_done_pulse), .tx_ninth_bit(tx_ninth_bit), .char_size_sel(char_size_sel),
    .two_stop_sel(two_stop_sel), .baud_div_high(baud_div_high), .rx_complete_flag(rx_complete_flag));
  //--------------------------------------------------------------
  // bus and compare helpers
  //--------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // n back-to-back reads of one address, each answer taken in the cycle after its strobe
  task automatic rdn(input logic [2:0] a, input int n);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (i == n - 1) reg_rd <= 1'b0;
      #1 got[i] = reg_rdata;
    end
  endtask : rdn
  // two back-to-back reads of different addresses, answers in got[0] and got[1]
  task automatic rd_two(input logic [2:0] a0, input logic [2:0] a1);
    @(posedge sys_clk);
    reg_addr <= a0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_addr <= a1;
    #1 got[0] = reg_rdata;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got[1] = reg_rdata;
  endtask : rd_two
  task automatic frame(input logic [7:0] d, input logic b8, input logic st, input logic kept);
    node.send(d, b8, st);
    #1 chk("rx_complete_flag", {7'h0, kept}, {7'h0, rx_complete_flag});
  endtask : frame
  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  task automatic t_reset_values;
    rdn(umaf_pkg::OFF_SHARED, 3);
    chk("shared single", umaf_pkg::BAUD_HI_RESET, got[0]);
    chk("shared second", umaf_pkg::CFG_RESET, got[1]);
    chk("shared third", umaf_pkg::CFG_RESET, got[2]);
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("ctrl_status_a", 8'h00, got[0]);
    rdn(3'h5, 1);
    chk("unmapped", 8'h00, got[0]);
    chk("char_size_sel", {5'h0, umaf_pkg::SIZE_EIGHT}, {5'h0, char_size_sel});
    $display("test reset_values done");
  endtask : t_reset_values
  task automatic t_shared_access;
    wr(umaf_pkg::OFF_SHARED, 8'h02);
    wr(umaf_pkg::OFF_SHARED, 8'h8e);
    #1 chk("baud_div_high", 8'h02, baud_div_high);
    chk("two_stop_sel", 8'h01, {7'h0, two_stop_sel});
    rdn(umaf_pkg::OFF_SHARED, 2);
    chk("shared single", 8'h02, got[0]);
    chk("shared double", 8'h8e, got[1]);
    rdn(umaf_pkg::OFF_CSA, 1);
    rdn(umaf_pkg::OFF_SHARED, 1);
    chk("shared after gap", 8'h02, got[0]);
    // a read elsewhere right before must not count as the first of a pair
    rd_two(umaf_pkg::OFF_CSA, umaf_pkg::OFF_SHARED);
    chk("ctrl_status_a", 8'h00, got[0]);
    chk("shared after other read", 8'h02, got[1]);
    $display("test shared_access done");
  endtask : t_shared_access
  task automatic t_filter_eight;
    wr(umaf_pkg::OFF_CSA, 8'h01);
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("filter enable", 8'h01, got[0]);
    frame(8'h33, 1'b1, 1'b0, 1'b0);
    frame(8'h5a, 1'b0, 1'b1, 1'b1);
    rdn(umaf_pkg::OFF_DATA, 1);
    chk("address frame", 8'h5a, got[0]);
    #1 chk("rx_complete_flag", 8'h00, {7'h0, rx_complete_flag});
    wr(umaf_pkg::OFF_CSA, 8'h00);
    frame(8'h44, 1'b0, 1'b0, 1'b1);
    rdn(umaf_pkg::OFF_DATA, 1);
    chk("data frame", 8'h44, got[0]);
    wr(umaf_pkg::OFF_CSA, 8'h01);
    frame(8'h55, 1'b0, 1'b0, 1'b0);
    rdn(umaf_pkg::OFF_DATA, 1);
    chk("data kept", 8'h44, got[0]);
    $display("test filter_eight done");
  endtask : t_filter_eight
  task automatic t_filter_nine;
    wr(umaf_pkg::OFF_CSB, 8'h05);
    wr(umaf_pkg::OFF_SHARED, 8'h86);
    wr(umaf_pkg::OFF_CSA, 8'h01);
    #1 chk("char_size_sel", {5'h0, umaf_pkg::SIZE_NINE}, {5'h0, char_size_sel});
    frame(8'h11, 1'b0, 1'b1, 1'b0);
    frame(8'h22, 1'b1, 1'b0, 1'b1);
    rdn(umaf_pkg::OFF_CSB, 1);
    chk("ctrl_status_b", 8'h07, got[0]);
    rdn(umaf_pkg::OFF_DATA, 1);
    chk("address frame", 8'h22, got[0]);
    wr(umaf_pkg::OFF_CSA, 8'h00);
    #1 chk("tx_ninth_bit", 8'h01, {7'h0, tx_ninth_bit});
    chk("two_stop_sel", 8'h00, {7'h0, two_stop_sel});
    $display("test filter_nine done");
  endtask : t_filter_nine
  task automatic t_tx_complete;
    wr(umaf_pkg::OFF_CSA, 8'h01);
    @(posedge sys_clk);
    tx_done_pulse <= 1'b1;
    @(posedge sys_clk);
    tx_done_pulse <= 1'b0;
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("ctrl_status_a", 8'h41, got[0]);
    wr(umaf_pkg::OFF_CSA, 8'h41);
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("ctrl_status_a", 8'h01, got[0]);
    // hardware set and software clear in one cycle: the set wins
    @(posedge sys_clk);
    reg_addr <= umaf_pkg::OFF_CSA;
    reg_wdata <= 8'h41;
    reg_wr <= 1'b1;
    tx_done_pulse <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    tx_done_pulse <= 1'b0;
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("set beats clear", 8'h41, got[0]);
    $display("test tx_complete done");
  endtask : t_tx_complete
  task automatic t_mid_reset;
    frame(8'h66, 1'b1, 1'b0, 1'b1);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    #1 chk("baud_div_high", umaf_pkg::BAUD_HI_RESET, baud_div_high);
    chk("rx_complete_flag", 8'h00, {7'h0, rx_complete_flag});
    rdn(umaf_pkg::OFF_CSA, 1);
    chk("ctrl_status_a", 8'h00, got[0]);
    rdn(umaf_pkg::OFF_SHARED, 2);
    chk("shared single", umaf_pkg::BAUD_HI_RESET, got[0]);
    chk("shared double", umaf_pkg::CFG_RESET, got[1]);
    $display("test mid_reset done");
  endtask : t_mid_reset
  //--------------------------------------------------------------
  // verdict and main sequence
  //--------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_shared_access();
    t_filter_eight();
    t_filter_nine();
    t_tx_complete();
    t_mid_reset();
    final_report();
  end
  // a hang past the bound counts as a mismatch
  initial begin
    #50000;
    fails++;
    final_report();
  end
endmodule : umaf_top_tb_top
`default_nettype wire
